//--- masc_defines.vh
// Constants for the multichannel sequence control block.
// Included by the design files; holds definitions only.
`ifndef MASC_DEFINES_VH
`define MASC_DEFINES_VH

`define MASC_NUM_CH 6
`define MASC_CH_W 3
`define MASC_RES_W 14
`define MASC_SLOT_LEN 5'h10
`define MASC_SLOT_W 5
`define MASC_SEL_W 3
`define MASC_SEL_ONE 3'h0
`define MASC_SEL_ALL 3'h5
`define MASC_LAST_CH 3'h5
`define MASC_FIFO_W 17
`define MASC_FIFO_D 16
`define MASC_FIFO_AW 4
`define MASC_MSB_POS 13
`define MASC_SYNC_W 5
`define MASC_SYNC_TRIG 4
`define MASC_SYNC_SEL_HI 3
`define MASC_SYNC_SEL_LO 1
`define MASC_SYNC_POL 0

`endif

//--- masc_fifo.v
// Result FIFO: flip-flop storage, valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
`include "masc_defines.vh"

module masc_fifo #(
    parameter WIDTH = `MASC_FIFO_W,
    parameter DEPTH = `MASC_FIFO_D,
    parameter AW = `MASC_FIFO_AW
) (
    input wire clk_i, // Clock
    input wire rstn_i, // Async reset, active low
    input wire in_valid_i, // Write request
    output wire in_ready_o, // Not full
    input wire [WIDTH-1:0] in_data_i, // Write data
    output wire out_valid_o, // Not empty
    input wire out_ready_i, // Read accept
    output wire [WIDTH-1:0] out_data_o // Head word
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire do_wr;
    wire do_rd;
    integer i;

    assign in_ready_o = (count_reg != DEPTH[AW:0]);
    assign out_valid_o = (count_reg != {(AW+1){1'b0}});
    assign do_wr = in_valid_i && in_ready_o;
    assign do_rd = out_valid_o && out_ready_i;
    assign out_data_o = mem_reg[rd_ptr_reg];

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_reg[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (do_wr) begin
                mem_reg[wr_ptr_reg] <= in_data_i;
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // masc_fifo

`default_nettype wire

//--- masc_seq_ctrl.v
// Conversion sequencer and serial result output for a six-pair
// simultaneous-sampling converter. Assumes clk_i is the serial clock
// domain; trigger and selects come from pins and are synchronised.
`timescale 1ns/1ns
`default_nettype none
`include "masc_defines.vh"

// What this block does
// R1: Select code zero converts only pair 0 after each acquisition.
// R2: Each select increment adds the next pair; codes five to seven convert all six.
// R3: A frame is one common acquisition then the selected pairs in ascending order.
// R4: The host holds the channel-count select through a conversion and the next one.
// R5: A stored result stays until that same channel is converted again.
// R6: While converting a set, the previous results of those positions shift out.
// R7: All twelve inputs of the six pairs are sampled at one instant.
// R8: Polarity low means unipolar range, high means bipolar symmetric range.
// R9: The host holds the polarity select through a conversion and the next one.
// R10: After a polarity change the host waits a full acquisition before triggering.
// R11: The reader inverts the MSB of the first frame after a polarity change.
// R12: Results are two's complement in bipolar mode, straight binary in unipolar.
// R13: A rising trigger edge holds all inputs and starts a frame.
// R14: The host gives sixteen serial clocks per selected channel, ninety-six at most.
// R15: Each result is fourteen bits MSB first, one bit per clock in a 16-clock slot.
// R16: Selects are sampled at frame start and used unchanged for the whole frame.
module masc_seq_ctrl (
    input wire clk_i, // Serial clock, 10 MHz
    input wire rstn_i, // Async reset, active low
    input wire conversion_trigger_i, // Frame start, rising edge
    input wire count_select_msb_i, // Channel count select bit 2
    input wire count_select_mid_i, // Channel count select bit 1
    input wire count_select_lsb_i, // Channel count select bit 0
    input wire polarity_select_i, // 1 = bipolar
    input wire [`MASC_NUM_CH*`MASC_RES_W-1:0] input_pair_n_i, // Quantised offset-binary codes
    output reg serial_data_o, // Serial result bit
    output reg busy_o, // Frame in progress
    output reg [`MASC_CH_W-1:0] slot_channel_o, // Channel being shifted
    output reg [`MASC_RES_W-1:0] word_o, // Word converted last
    output reg word_valid_o // Word pulse
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ACQ = 2'h1;
    localparam ST_CONVERSION_TRIGGER = 2'h2;

    // Last-channel index for a select code
    function [`MASC_CH_W-1:0] last_of;
        input [`MASC_SEL_W-1:0] sel;
        begin
            if (sel >= `MASC_SEL_ALL)
                last_of = `MASC_LAST_CH; // [R2]
            else
                last_of = sel; // [R1]
        end
    endfunction

    // Result coding: flip the MSB of offset binary for two's complement
    function [`MASC_RES_W-1:0] code_of;
        input [`MASC_RES_W-1:0] raw;
        input polarity_select;
        begin
            code_of = raw;
            if (polarity_select)
                code_of[`MASC_MSB_POS] = ~raw[`MASC_MSB_POS]; // [R12] [R8]
        end
    endfunction

    reg [`MASC_SYNC_W-1:0] sync1_reg;
    reg [`MASC_SYNC_W-1:0] sync2_reg;
    reg trig_d_reg;
    reg [1:0] state_reg;
    reg [`MASC_CH_W-1:0] last_ch_reg;
    reg bip_reg;
    reg [`MASC_CH_W-1:0] ch_reg;
    reg [`MASC_SLOT_W-1:0] bit_reg;
    reg [`MASC_NUM_CH*`MASC_RES_W-1:0] hold_reg;
    reg [`MASC_RES_W-1:0] result_reg [0:`MASC_NUM_CH-1];
    reg [`MASC_RES_W:0] shift_reg;

    wire [`MASC_SEL_W-1:0] sel_sync;
    wire trig_rise;
    wire slot_end;
    wire [`MASC_RES_W-1:0] hold_word;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`MASC_FIFO_W-1:0] fifo_out_data;
    wire fifo_pop;
    wire [`MASC_FIFO_W-1:0] fifo_in_data;

    assign sel_sync = sync2_reg[`MASC_SYNC_SEL_HI:`MASC_SYNC_SEL_LO];
    assign trig_rise = sync2_reg[`MASC_SYNC_TRIG] && !trig_d_reg;
    assign slot_end = (bit_reg == (`MASC_SLOT_LEN - 5'h1));
    assign hold_word = hold_reg[ch_reg*`MASC_RES_W +: `MASC_RES_W];
    assign fifo_in_data = {ch_reg, code_of(hold_word, bip_reg)};
    assign fifo_pop = fifo_out_valid;

    // Converted words queue here before landing in the result store
    masc_fifo #(
        .WIDTH(`MASC_FIFO_W),
        .DEPTH(`MASC_FIFO_D),
        .AW(`MASC_FIFO_AW)
    ) u_fifo (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(state_reg == ST_CONVERSION_TRIGGER && slot_end),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out_data)
    );

    // Two-flop synchronisers for the pin inputs
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_reg <= {`MASC_SYNC_W{1'b0}};
            sync2_reg <= {`MASC_SYNC_W{1'b0}};
            trig_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {conversion_trigger_i, count_select_msb_i, count_select_mid_i,
                          count_select_lsb_i, polarity_select_i};
            sync2_reg <= sync1_reg;
            trig_d_reg <= sync2_reg[`MASC_SYNC_TRIG];
        end
    end

    genvar g;
    generate
        for (g = 0; g < `MASC_NUM_CH; g = g + 1) begin : g_store
            always @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    result_reg[g] <= {`MASC_RES_W{1'b0}};
                end else if (fifo_pop && fifo_out_data[`MASC_FIFO_W-1 -: `MASC_CH_W] == g) begin
                    result_reg[g] <= fifo_out_data[`MASC_RES_W-1:0]; // [R5]
                end
            end
        end
    endgenerate

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_IDLE;
            last_ch_reg <= `MASC_SEL_ONE;
            bip_reg <= 1'b0;
            ch_reg <= {`MASC_CH_W{1'b0}};
            bit_reg <= {`MASC_SLOT_W{1'b0}};
            hold_reg <= {(`MASC_NUM_CH*`MASC_RES_W){1'b0}};
            shift_reg <= {(`MASC_RES_W+1){1'b0}};
            serial_data_o <= 1'b0;
            busy_o <= 1'b0;
            slot_channel_o <= {`MASC_CH_W{1'b0}};
            word_o <= {`MASC_RES_W{1'b0}};
            word_valid_o <= 1'b0;
        end else begin
            word_valid_o <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    serial_data_o <= 1'b0;
                    // Edges during a frame are ignored by design
                    if (trig_rise) begin // [R13]
                        hold_reg <= input_pair_n_i; // [R7]
                        last_ch_reg <= last_of(sel_sync); // [R16] [R4]
                        bip_reg <= sync2_reg[`MASC_SYNC_POL]; // [R16] [R9]
                        state_reg <= ST_ACQ;
                        busy_o <= 1'b1;
                    end
                end
                ST_ACQ: begin
                    ch_reg <= {`MASC_CH_W{1'b0}}; // [R3]
                    bit_reg <= {`MASC_SLOT_W{1'b0}};
                    shift_reg <= {result_reg[0], 1'b0}; // [R6]
                    slot_channel_o <= {`MASC_CH_W{1'b0}};
                    state_reg <= ST_CONVERSION_TRIGGER;
                end
                ST_CONVERSION_TRIGGER: begin
                    // MSB first, zeros after bit 0 fill the slot
                    serial_data_o <= shift_reg[`MASC_RES_W]; // [R15]
                    shift_reg <= {shift_reg[`MASC_RES_W-1:0], 1'b0};
                    bit_reg <= bit_reg + 5'h1;
                    if (slot_end) begin // [R14]
                        word_o <= code_of(hold_word, bip_reg);
                        word_valid_o <= fifo_in_ready;
                        bit_reg <= {`MASC_SLOT_W{1'b0}};
                        if (ch_reg == last_ch_reg) begin
                            state_reg <= ST_IDLE; // [R3]
                            busy_o <= 1'b0;
                        end else begin
                            ch_reg <= ch_reg + 3'h1; // [R3]
                            slot_channel_o <= ch_reg + 3'h1;
                            shift_reg <= {result_reg[ch_reg + 3'h1], 1'b0}; // [R6]
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // masc_seq_ctrl

`default_nettype wire

//--- masc_seq_ctrl_properties.sv
// Checker on the sequencer's ports: frame length, slots, word pulses.
// Assumes a free-running clk_i and the settled select pins.
`timescale 1ns/1ns
`default_nettype none
`include "masc_defines.vh"
module masc_seq_ctrl_props (
    input wire logic clk_i, // Clock
    input wire logic rstn_i, // Reset
    input wire logic conversion_trigger_i, // Trigger
    input wire logic count_select_msb_i, // Sel 2
    input wire logic count_select_mid_i, // Sel 1
    input wire logic count_select_lsb_i, // Sel 0
    input wire logic polarity_select_i, // Polarity
    input wire logic [`MASC_NUM_CH*`MASC_RES_W-1:0] input_pair_n_i, // Codes
    input wire logic serial_data_o, // Serial bit
    input wire logic busy_o, // Busy
    input wire logic [`MASC_CH_W-1:0] slot_channel_o, // Slot
    input wire logic [`MASC_RES_W-1:0] word_o, // Word
    input wire logic word_valid_o // Pulse
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_busy8;
        busy_o [*8];
    endsequence
    sequence s_one_slot;
        s_busy8 ##1 s_busy8 ##1 busy_o;
    endsequence
    chk_frame_min: assert property ($rose(busy_o) |-> s_one_slot)
        else $error("Frame too short");
    chk_frame_max: assert property ($rose(busy_o) |-> ##[17:97] !busy_o)
        else $error("Frame too long");
    chk_code_zero: assert property ($rose(busy_o) && !count_select_msb_i &&
        !count_select_mid_i && !count_select_lsb_i |-> ##17 !busy_o) else $error("Code zero");
    chk_trig_start: assert property ($rose(conversion_trigger_i) && !busy_o
        |-> ##[1:5] $rose(busy_o)) else $error("Trigger missed");
    chk_slot_step: assert property ($changed(slot_channel_o) |-> slot_channel_o == 3'h0
        || slot_channel_o == $past(slot_channel_o) + 1) else $error("Slot order");
    chk_slot_limit: assert property (slot_channel_o <= 3'h5)
        else $error("Slot range");
    chk_slot_hold: assert property ($changed(slot_channel_o) && slot_channel_o != 3'h0
        |=> $stable(slot_channel_o) [*8] ##1 $stable(slot_channel_o) [*7]) else $error("Slot");
    chk_word_pulse: assert property (word_valid_o |=> !word_valid_o)
        else $error("Word pulse");
    chk_word_frame: assert property (word_valid_o |-> $past(busy_o))
        else $error("Word outside frame");
    chk_idle_low: assert property (!busy_o && !$past(busy_o) |-> !serial_data_o)
        else $error("Serial idle");
endmodule // masc_seq_ctrl_props
bind masc_seq_ctrl masc_seq_ctrl_props masc_seq_ctrl_props_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .conversion_trigger_i(conversion_trigger_i), .count_select_msb_i(count_select_msb_i),
    .count_select_mid_i(count_select_mid_i), .count_select_lsb_i(count_select_lsb_i),
    .polarity_select_i(polarity_select_i), .input_pair_n_i(input_pair_n_i),
    .serial_data_o(serial_data_o), .busy_o(busy_o), .slot_channel_o(slot_channel_o),
    .word_o(word_o), .word_valid_o(word_valid_o));
`default_nettype wire

//--- masc_host_model.sv
// Host model: pulses the trigger, then reads one frame of slots.
// Assumes registered outputs; samples 1 ns after each rising edge.
`timescale 1ns/1ns
`default_nettype none
module masc_host_model (
    input wire logic clk_i, // Clock
    input wire logic busy_i, // Busy
    input wire logic serial_data_i, // Serial bit
    input wire logic [2:0] slot_channel_i, // Slot
    input wire logic [13:0] word_i, // Word
    input wire logic word_valid_i, // Pulse
    output logic trigger_o // Trigger
);
    logic [13:0] rd [0:5];
    logic [13:0] cv [0:5];
    int nv;
    logic ok;
    initial trigger_o = 1'b0;
    task automatic grab;
        #1;
        if (word_valid_i === 1'b1 && nv < 6) cv[nv] = word_i;
        if (word_valid_i === 1'b1) nv++;
    endtask
    task automatic frame(input int n);
        int k;
        int j;
        ok = 1'b1;
        nv = 0;
        @(posedge clk_i);
        trigger_o <= 1'b1;
        for (j = 0; j < 12 && busy_i !== 1'b1; j++) begin
            @(posedge clk_i);
            trigger_o <= 1'b0;
            #1;
        end
        if (busy_i !== 1'b1) ok = 1'b0;
        for (k = 0; k < n; k++) begin
            for (j = 0; j < 16; j++) begin
                @(posedge clk_i);
                trigger_o <= (k == 0 && j == 4); // Must be ignored while busy
                grab();
                if (j >= 1 && j <= 14) rd[k] = {rd[k][12:0], serial_data_i};
                if (j == 1 && slot_channel_i !== 3'(k)) ok = 1'b0;
            end
        end
        if (busy_i !== 1'b1) ok = 1'b0;
        @(posedge clk_i);
        grab();
        if (busy_i !== 1'b0) ok = 1'b0;
    endtask
endmodule // masc_host_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench: frames of every select code and polarity.
// Assumes the host model reads each frame; expectations kept here.
`timescale 1ns/1ns
`default_nettype none
`include "masc_defines.vh"
module testbench;
    logic clk_i = 1'b0, rstn_i = 1'b0, bip_r = 1'b0;
    logic [2:0] sel_r = 3'h0;
    logic [`MASC_NUM_CH*`MASC_RES_W-1:0] pairs_r = '0;
    logic [13:0] store [0:5];
    logic [13:0] rawst [0:5];
    logic pbst [0:5];
    wire trig, sdo, busy, wv;
    wire [2:0] slot;
    wire [13:0] word;
    int miscompares = 0, checks = 0, s;
    masc_seq_ctrl masc_seq_ctrl_i (.clk_i(clk_i), .rstn_i(rstn_i), .conversion_trigger_i(trig),
        .count_select_msb_i(sel_r[2]), .count_select_mid_i(sel_r[1]),
        .count_select_lsb_i(sel_r[0]), .polarity_select_i(bip_r), .input_pair_n_i(pairs_r),
        .serial_data_o(sdo), .busy_o(busy), .slot_channel_o(slot), .word_o(word),
        .word_valid_o(wv));
    masc_host_model host_i (.clk_i(clk_i), .busy_i(busy), .serial_data_i(sdo),
        .slot_channel_i(slot), .word_i(word), .word_valid_i(wv), .trigger_o(trig));
    initial forever #50 clk_i = ~clk_i;
    task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic run(input logic [2:0] sel, input logic polarity_select, input logic [13:0] base);
        int n;
        int k;
        logic [13:0] raw [0:5];
        n = (sel > 3'h5) ? 6 : sel + 1;
        @(posedge clk_i);
        for (k = 0; k < 6; k++) begin
            raw[k] = base + 14'(k * 'h0123);
            pairs_r[k*14 +: 14] <= raw[k];
        end
        sel_r <= sel;
        bip_r <= polarity_select;
        repeat (4) @(posedge clk_i); // Settling after a polarity change
        fork
            host_i.frame(n);
            begin
                @(posedge busy);
                @(posedge clk_i);
                pairs_r <= ~pairs_r; // Inputs after the capture must not matter
            end
        join
        check("frame", 14'h1, 14'(host_i.ok));
        check("words", 14'(n), 14'(host_i.nv));
        for (k = 0; k < n; k++) begin
            check("previous", store[k], host_i.rd[k]);
            if (pbst[k] != polarity_select) check("reread", rawst[k] ^ {polarity_select, 13'h0}, host_i.rd[k] ^ 14'h2000);
            store[k] = raw[k] ^ {polarity_select, 13'h0};
            rawst[k] = raw[k];
            pbst[k] = polarity_select;
            check("converted", store[k], host_i.cv[k]);
        end
    endtask
    initial begin
        #600000;
        miscompares++;
        results();
    end
    initial begin
        for (s = 0; s < 6; s++) begin
            store[s] = 14'h0;
            rawst[s] = 14'h0;
            pbst[s] = 1'b0;
        end
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        run(3'h5, 1'b0, 14'h1000);
        run(3'h3, 1'b0, 14'h2000);
        run(3'h1, 1'b0, 14'h0a00);
        run(3'h5, 1'b0, 14'h3000);
        for (s = 0; s < 8; s++) run(3'(s), s[1], 14'h3ff0 + 14'(s));
        results();
    end
endmodule // testbench
`default_nettype wire
